/* mic_defs.vh */
// register map, fields, reset values and counts
// definitions only, included by every design file
`ifndef MIC_DEFS_VH
`define MIC_DEFS_VH
`define ADDR_MIC_A 8'h00
`define ADDR_LCM_A 8'h04
`define ADDR_CHC_A 8'h08
`define ADDR_VRB_A 8'h0C
`define ADDR_IRQ_STAT 8'h10
`define ADDR_CHAN_STAT 8'h14
`define ADDR_MISC 8'h18
`define ADDR_MIC_B 8'h20
`define ADDR_LCM_B 8'h24
`define ADDR_CHC_B 8'h28
`define ADDR_VRB_B 8'h2C
`define CMD_RST_B 2'b01
`define CMD_RST_A 2'b10
`define CMD_RST_FULL 2'b11
`define MIC_SOFT_ACK 5
`define MIC_STAT_HIGH 4
`define MIC_MASTER_EN 3
`define MIC_LOWER_OFF 2
`define MIC_NO_VEC 1
`define MIC_VEC_STAT 0
`define MIC_FORCE_KEEP 8'h1C
`define MIC_RESET 8'h00
`define LC_PRESET 7
`define LC_GOAP 4
`define LC_MARK 3
`define LC_ABORT 2
`define LC_LOOP 1
`define LC_RESET 8'h00
`define LC_CHAN_KEEP 8'h60
`define CHC_RESET 12'h0C0
`define CHC_RX_EN 4
`define CHC_TX_EN 5
`define CHC_AUTO_FLAG 10
`define MODE_ASYNC 2'b00
`define MODE_SDLC 2'b10
`define CRC_GOOD_RESIDUE 16'h1D0F
`define CRC_ALL_ONES 16'hFFFF
`define CRC_ALL_ZEROS 16'h0000
`define RESET_EXTRA_CLKS 3'h4
`define IRQ_CLR_SVC_BIT 8
`define VEC_IDLE_CODE 3'h3
`define VEC_BASE_RESET 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* vector_encode.v */
// interrupt vector encoder: picks the highest pending source and
// inserts its code into the vector; purely combinational
`timescale 1ns/1ps
`include "mic_defs.vh"
module vector_encode (
  input wire [7:0] pending,
  input wire [7:0] base,
  input wire status_high,
  output reg [2:0] code,
  output reg [7:0] vector
);
  integer i;
  always @*
  begin
    code = `VEC_IDLE_CODE;
    for (i = 0; i < 8; i = i + 1)
      if (pending[i])
        code = i[2:0];
    vector = base;
    if (status_high)
    begin
      vector[4] = code[2];
      vector[5] = code[1];
      vector[6] = code[0];
    end
    else
    begin
      vector[3] = code[2];
      vector[2] = code[1];
      vector[1] = code[0];
    end
  end
endmodule

/* line_channel.v */
// one channel's line control, loop sequencing, crc and underrun
// assumes one-cycle event pulses from the serial engine
`timescale 1ns/1ps
`include "mic_defs.vh"
module line_channel (
  input wire aclk,
  input wire hard_rst,
  input wire chan_rst,
  input wire lc_we,
  input wire chc_we,
  input wire [11:0] wdata,
  input wire end_of_poll,
  input wire flag_out,
  input wire byte_done,
  input wire underrun,
  input wire closing_done,
  input wire frame_end,
  input wire [15:0] crc_residue,
  output reg [7:0] line_control_misc,
  output reg [11:0] chan_control,
  output reg [15:0] crc_preset,
  output reg crc_invert,
  output reg crc_ok,
  output reg loop_gate,
  output reg loop_delay,
  output reg loop_tx_active,
  output reg mark_idle,
  output reg send_open_flag,
  output reg send_abort,
  output reg send_crc,
  output reg eom_event,
  output reg txe_event
);
  localparam LP_OFF = 2'd0;
  localparam LP_PASS = 2'd1;
  localparam LP_DELAY = 2'd2;
  localparam LP_ACTIVE = 2'd3;
  reg [1:0] loop_state;
  reg [1:0] next_loop_state;
  reg in_underrun;
  wire sdlc = chan_control[9:8] == `MODE_SDLC;
  wire loop_bit = line_control_misc[`LC_LOOP];
  wire loop_on = sdlc & loop_bit;
  wire goap = line_control_misc[`LC_GOAP] & loop_bit & (chan_control[9:8] != `MODE_ASYNC);
  wire abort_sel = line_control_misc[`LC_ABORT] & ~loop_on;
  always @*
  begin
    next_loop_state = loop_state;
    case (loop_state)
      LP_OFF:
        if (loop_on)
          next_loop_state = LP_PASS;
      LP_PASS:
        if (!loop_on)
          next_loop_state = LP_OFF;
        else if (end_of_poll && goap)
          next_loop_state = LP_ACTIVE;
      LP_DELAY:
        if (end_of_poll && !loop_bit)
          next_loop_state = LP_OFF;
        else if (end_of_poll && goap)
          next_loop_state = LP_ACTIVE;
      default:
        if (flag_out && !goap)
          next_loop_state = LP_DELAY;
    endcase
  end
  always @(posedge aclk)
  begin
    if (hard_rst)
    begin
      line_control_misc <= `LC_RESET;
      chan_control <= `CHC_RESET;
    end
    else if (chan_rst)
    begin
      line_control_misc <= line_control_misc & `LC_CHAN_KEEP;
      chan_control <= `CHC_RESET;
    end
    else
    begin
      if (lc_we)
        line_control_misc <= wdata[7:0];
      if (chc_we)
        chan_control <= wdata;
    end
  end
  always @(posedge aclk)
  begin
    if (hard_rst || chan_rst)
    begin
      loop_state <= LP_OFF;
      loop_gate <= 1'b0;
      loop_delay <= 1'b0;
      loop_tx_active <= 1'b0;
      crc_preset <= `CRC_ALL_ZEROS;
      crc_invert <= 1'b0;
      crc_ok <= 1'b0;
      mark_idle <= 1'b0;
      send_open_flag <= 1'b0;
      send_abort <= 1'b0;
      send_crc <= 1'b0;
      eom_event <= 1'b0;
      txe_event <= 1'b0;
      in_underrun <= 1'b0;
    end
    else
    begin
      loop_state <= next_loop_state;
      loop_gate <= next_loop_state == LP_PASS;
      loop_delay <= next_loop_state[1];
      loop_tx_active <= next_loop_state == LP_ACTIVE;
      if (chan_control[9:8] != `MODE_ASYNC && line_control_misc[`LC_PRESET])
        crc_preset <= `CRC_ALL_ONES;
      else
        crc_preset <= `CRC_ALL_ZEROS;
      crc_invert <= sdlc;
      if (frame_end && sdlc)
        crc_ok <= crc_residue == `CRC_GOOD_RESIDUE;
      send_open_flag <= sdlc & (~line_control_misc[`LC_MARK] | chan_control[`CHC_AUTO_FLAG]);
      send_abort <= underrun & sdlc & abort_sel;
      send_crc <= underrun & sdlc & ~abort_sel;
      eom_event <= underrun & sdlc;
      if (underrun && sdlc)
        in_underrun <= 1'b1;
      else if (closing_done && in_underrun)
        in_underrun <= 1'b0;
      txe_event <= closing_done & in_underrun;
      if (closing_done && in_underrun && abort_sel && line_control_misc[`LC_MARK])
        mark_idle <= 1'b1;
      else if (byte_done && !loop_on)
        mark_idle <= sdlc & line_control_misc[`LC_MARK];
    end
  end
endmodule

/* master_irq_and_line_control.v */
// top: axi4-lite registers, reset commands, interrupt latches, chain
// assumes one clock and a synchronous active-low reset
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "mic_defs.vh"
// Summary of operation
// - top two control bits: 00 none, 01 reset B, 10 reset A, 11 full reset
// - channel reset stops rx/tx, marks line, modem high, clears its interrupts
// - full reset equals hardware reset, keeps shift bit, loads written enable bits
// - one master register, written through either channel, interrupt bits hardware reset
// - soft acknowledge bit makes vector read act as an interrupt acknowledge
// - status position bit puts status at vector bits 6..4 or 1..3
// - codes 0-3 channel B, 4-7 channel A: tx empty, ext, rx, special
// - master enable off passes chain unless under service; no new service latch
// - lower chain disable forces chain enable output low; hardware reset clears it
// - suppress vector keeps bus lines undriven during acknowledge
// - vector carries status only when status bit set and suppress clear
// - crc preset ones or zeros, ignored in async, cleared by resets
// - sdlc inverts sent crc, checks residue against fixed pattern
// - two encoding bits pick NRZ, NRZI, FM1, FM0; hardware reset gives NRZ
// - loop mode first passes line through gates; on-loop after poll bit and end of poll
// - active on loop: poll bit checked per flag; clear returns to one-bit delay
// - poll bit ignored outside loop mode; host clears it before crc
// - sdlc idle is flags or ones, chosen per byte, ignored in loop mode
// - automatic opening flag sends flag even with mark idle
// - underrun sends abort and flag or crc; with mark idle then ones
// - underrun raises end-of-message at start, tx empty at end of closing
// - loop bit connects line through and starts searching for end of poll
module master_irq_and_line_control (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire chain_enable_in,
  output reg chain_enable_out,
  input wire acknowledge_strobe,
  output reg int_n,
  output reg [7:0] muxed_bus_lines_out,
  output reg muxed_bus_lines_oe,
  input wire rx_avail_a,
  input wire rx_special_a,
  input wire end_of_poll_a,
  input wire flag_out_a,
  input wire byte_done_a,
  input wire underrun_a,
  input wire closing_done_a,
  input wire frame_end_a,
  input wire [15:0] crc_residue_a,
  input wire rx_avail_b,
  input wire rx_special_b,
  input wire end_of_poll_b,
  input wire flag_out_b,
  input wire byte_done_b,
  input wire underrun_b,
  input wire closing_done_b,
  input wire frame_end_b,
  input wire [15:0] crc_residue_b,
  output wire rx_enable_a,
  output wire tx_enable_a,
  output wire [1:0] modem_ctrl_a,
  output wire [1:0] encoding_a,
  output wire [15:0] crc_preset_a,
  output wire crc_invert_a,
  output wire crc_ok_a,
  output wire loop_gate_a,
  output wire loop_delay_a,
  output wire loop_tx_active_a,
  output wire mark_idle_a,
  output wire send_open_flag_a,
  output wire send_abort_a,
  output wire send_crc_a,
  output wire rx_enable_b,
  output wire tx_enable_b,
  output wire [1:0] modem_ctrl_b,
  output wire [1:0] encoding_b,
  output wire [15:0] crc_preset_b,
  output wire crc_invert_b,
  output wire crc_ok_b,
  output wire loop_gate_b,
  output wire loop_delay_b,
  output wire loop_tx_active_b,
  output wire mark_idle_b,
  output wire send_open_flag_b,
  output wire send_abort_b,
  output wire send_crc_b
);
  reg [7:0] master_interrupt_control, vector_base, pend, svc, aw_addr, ack_vector;
  reg shift_left, force_q, aw_full, w_full, ack_q, ack_owner;
  reg [2:0] rst_cnt_a, rst_cnt_b;
  reg [31:0] w_data, rd_data;
  reg [3:0] w_strb;
  reg mic_we, lc_we_a, lc_we_b, chc_we_a, chc_we_b, vb_we, stat_we, misc_we, wr_err, rd_err;
  wire [7:0] lc_a, lc_b, vec_mod;
  wire [11:0] chc_a, chc_b;
  wire eom_a, eom_b, txe_a, txe_b;
  wire [2:0] code;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire [7:0] wa = aw_hs ? s_axi_awaddr : aw_addr;
  wire [31:0] wd = w_hs ? s_axi_wdata : w_data;
  wire [3:0] ws = w_hs ? s_axi_wstrb : w_strb;
  wire do_write = (aw_full | aw_hs) & (w_full | w_hs) & ~s_axi_bvalid;
  wire next_aw_full = ~do_write & (aw_full | aw_hs);
  wire next_w_full = ~do_write & (w_full | w_hs);
  wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);
  wire next_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0] wm = ws[0] ? wd[7:0] : master_interrupt_control;
  wire hard_rst = ~aresetn | force_q;
  wire chan_rst_a = rst_cnt_a != 3'h0;
  wire chan_rst_b = rst_cnt_b != 3'h0;
  wire master_en = master_interrupt_control[`MIC_MASTER_EN];
  wire int_active = master_en & (|pend) & ~(|svc);
  wire [7:0] events = {rx_special_a, rx_avail_a, eom_a, txe_a,
    rx_special_b, rx_avail_b, eom_b, txe_b};
  wire [7:0] ev_enable = {chc_a[3:0], chc_b[3:0]};
  wire [7:0] chan_clear = {{4{chan_rst_a}}, {4{chan_rst_b}}};
  wire vrb_read = ar_hs & (s_axi_araddr == `ADDR_VRB_A || s_axi_araddr == `ADDR_VRB_B);
  wire soft_ack = vrb_read & master_interrupt_control[`MIC_SOFT_ACK] & int_active;
  wire hw_ack = acknowledge_strobe & ~ack_q & chain_enable_in & int_active;

  // write decode; a write is applied at the edge where do_write is high
  always @*
  begin
    mic_we = 1'b0;
    lc_we_a = 1'b0;
    lc_we_b = 1'b0;
    chc_we_a = 1'b0;
    chc_we_b = 1'b0;
    vb_we = 1'b0;
    stat_we = 1'b0;
    misc_we = 1'b0;
    wr_err = 1'b0;
    if (wa == `ADDR_MIC_A || wa == `ADDR_MIC_B)
      mic_we = do_write;
    else if (wa == `ADDR_LCM_A)
      lc_we_a = do_write;
    else if (wa == `ADDR_LCM_B)
      lc_we_b = do_write;
    else if (wa == `ADDR_CHC_A)
      chc_we_a = do_write;
    else if (wa == `ADDR_CHC_B)
      chc_we_b = do_write;
    else if (wa == `ADDR_VRB_A || wa == `ADDR_VRB_B)
      vb_we = do_write;
    else if (wa == `ADDR_IRQ_STAT)
      stat_we = do_write;
    else if (wa == `ADDR_MISC)
      misc_we = do_write;
    else
      wr_err = 1'b1;
  end

  always @*
  begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (s_axi_araddr == `ADDR_MIC_A || s_axi_araddr == `ADDR_MIC_B)
      rd_data[7:0] = master_interrupt_control;
    else if (s_axi_araddr == `ADDR_LCM_A)
      rd_data[7:0] = lc_a;
    else if (s_axi_araddr == `ADDR_LCM_B)
      rd_data[7:0] = lc_b;
    else if (s_axi_araddr == `ADDR_CHC_A)
      rd_data[11:0] = chc_a;
    else if (s_axi_araddr == `ADDR_CHC_B)
      rd_data[11:0] = chc_b;
    else if (s_axi_araddr == `ADDR_VRB_A)
      rd_data[7:0] = vector_base;
    else if (s_axi_araddr == `ADDR_VRB_B)
      rd_data[7:0] = vec_mod;
    else if (s_axi_araddr == `ADDR_IRQ_STAT)
      rd_data[15:0] = {svc, pend};
    else if (s_axi_araddr == `ADDR_CHAN_STAT)
      rd_data[13:0] = {chan_rst_b, crc_ok_b, loop_tx_active_b, loop_delay_b,
        loop_gate_b, mark_idle_b, 1'b0, chan_rst_a, crc_ok_a, loop_tx_active_a,
        loop_delay_a, loop_gate_a, mark_idle_a, 1'b0};
    else if (s_axi_araddr == `ADDR_MISC)
      rd_data[0] = shift_left;
    else
      rd_err = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      if (aw_hs)
        aw_addr <= s_axi_awaddr;
      if (w_hs)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      s_axi_awready <= ~next_aw_full & ~next_bvalid;
      s_axi_wready <= ~next_w_full & ~next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write)
        s_axi_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
      s_axi_arready <= ~next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (ar_hs)
      begin
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
      end
    end
  end

  // reset commands; the master register itself clears only on aresetn
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      master_interrupt_control <= `MIC_RESET;
      shift_left <= 1'b0;
      force_q <= 1'b0;
    end
    else
    begin
      force_q <= mic_we & (wm[7:6] == `CMD_RST_FULL);
      if (mic_we && wm[7:6] == `CMD_RST_FULL)
        master_interrupt_control <= wm[7:0] & `MIC_FORCE_KEEP;
      else if (mic_we)
        master_interrupt_control <= {2'b00, wm[5:0]};
      if (misc_we && ws[0])
        shift_left <= wd[0];
    end
  end

  always @(posedge aclk)
  begin
    if (hard_rst)
    begin
      rst_cnt_a <= 3'h0;
      rst_cnt_b <= 3'h0;
      vector_base <= `VEC_BASE_RESET;
    end
    else
    begin
      if (mic_we && wm[7:6] == `CMD_RST_A)
        rst_cnt_a <= `RESET_EXTRA_CLKS;
      else if (chan_rst_a)
        rst_cnt_a <= rst_cnt_a - 3'h1;
      if (mic_we && wm[7:6] == `CMD_RST_B)
        rst_cnt_b <= `RESET_EXTRA_CLKS;
      else if (chan_rst_b)
        rst_cnt_b <= rst_cnt_b - 3'h1;
      if (vb_we && ws[0])
        vector_base <= wd[7:0];
    end
  end

  // pending and under-service latches; a new event wins over a clear, but a channel reset wins over a new service latch
  always @(posedge aclk)
  begin
    if (hard_rst)
    begin
      pend <= 8'h00;
      svc <= 8'h00;
    end
    else
    begin
      pend <= (pend & ~chan_clear & ~(stat_we && ws[0] ? wd[7:0] : 8'h00))
        | (events & ev_enable);
      if (soft_ack || hw_ack)
        svc[code] <= 1'b1;
      else if (stat_we && ws[1] && wd[`IRQ_CLR_SVC_BIT] && (|svc))
        svc <= svc & (svc - 8'h01);
      if (chan_rst_a)
        svc[7:4] <= 4'h0;
      if (chan_rst_b)
        svc[3:0] <= 4'h0;
    end
  end

  // daisy chain, interrupt output and acknowledge vector drive
  always @(posedge aclk)
  begin
    if (hard_rst)
    begin
      ack_q <= 1'b0;
      ack_owner <= 1'b0;
      ack_vector <= 8'h00;
      int_n <= 1'b1;
      chain_enable_out <= 1'b0;
      muxed_bus_lines_out <= 8'h00;
      muxed_bus_lines_oe <= 1'b0;
    end
    else
    begin
      ack_q <= acknowledge_strobe;
      if (acknowledge_strobe && !ack_q)
        ack_owner <= chain_enable_in & int_active;
      else if (!acknowledge_strobe)
        ack_owner <= 1'b0;
      if (acknowledge_strobe && !ack_q)
        ack_vector <= master_interrupt_control[`MIC_VEC_STAT] ? vec_mod : vector_base;
      int_n <= ~int_active | soft_ack | hw_ack;
      if (master_interrupt_control[`MIC_LOWER_OFF])
        chain_enable_out <= 1'b0;
      else if ((|svc) || soft_ack || hw_ack)
        chain_enable_out <= 1'b0;
      else if (master_en && (|pend))
        chain_enable_out <= 1'b0;
      else
        chain_enable_out <= chain_enable_in;
      muxed_bus_lines_out <= ack_vector;
      muxed_bus_lines_oe <= ack_owner & acknowledge_strobe
        & ~master_interrupt_control[`MIC_NO_VEC];
    end
  end

  assign rx_enable_a = chc_a[`CHC_RX_EN];
  assign tx_enable_a = chc_a[`CHC_TX_EN];
  assign modem_ctrl_a = chc_a[7:6];
  assign encoding_a = lc_a[6:5];
  assign rx_enable_b = chc_b[`CHC_RX_EN];
  assign tx_enable_b = chc_b[`CHC_TX_EN];
  assign modem_ctrl_b = chc_b[7:6];
  assign encoding_b = lc_b[6:5];

  vector_encode u_vec (
    .pending(pend), .base(vector_base),
    .status_high(master_interrupt_control[`MIC_STAT_HIGH]),
    .code(code), .vector(vec_mod)
  );

  line_channel u_chan_a (
    .aclk(aclk), .hard_rst(hard_rst), .chan_rst(chan_rst_a),
    .lc_we(lc_we_a & ws[0]), .chc_we(chc_we_a & ws[0] & ws[1]), .wdata(wd[11:0]),
    .end_of_poll(end_of_poll_a), .flag_out(flag_out_a), .byte_done(byte_done_a),
    .underrun(underrun_a), .closing_done(closing_done_a),
    .frame_end(frame_end_a), .crc_residue(crc_residue_a),
    .line_control_misc(lc_a), .chan_control(chc_a),
    .crc_preset(crc_preset_a), .crc_invert(crc_invert_a), .crc_ok(crc_ok_a),
    .loop_gate(loop_gate_a), .loop_delay(loop_delay_a),
    .loop_tx_active(loop_tx_active_a), .mark_idle(mark_idle_a),
    .send_open_flag(send_open_flag_a), .send_abort(send_abort_a),
    .send_crc(send_crc_a), .eom_event(eom_a), .txe_event(txe_a)
  );

  line_channel u_chan_b (
    .aclk(aclk), .hard_rst(hard_rst), .chan_rst(chan_rst_b),
    .lc_we(lc_we_b & ws[0]), .chc_we(chc_we_b & ws[0] & ws[1]), .wdata(wd[11:0]),
    .end_of_poll(end_of_poll_b), .flag_out(flag_out_b), .byte_done(byte_done_b),
    .underrun(underrun_b), .closing_done(closing_done_b),
    .frame_end(frame_end_b), .crc_residue(crc_residue_b),
    .line_control_misc(lc_b), .chan_control(chc_b),
    .crc_preset(crc_preset_b), .crc_invert(crc_invert_b), .crc_ok(crc_ok_b),
    .loop_gate(loop_gate_b), .loop_delay(loop_delay_b),
    .loop_tx_active(loop_tx_active_b), .mark_idle(mark_idle_b),
    .send_open_flag(send_open_flag_b), .send_abort(send_abort_b),
    .send_crc(send_crc_b), .eom_event(eom_b), .txe_event(txe_b)
  );
endmodule

/* mic_asserts.sv */
// port-level checker for the master interrupt and line control block
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
module mic_asserts (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire chain_enable_in,
  input wire chain_enable_out,
  input wire acknowledge_strobe,
  input wire int_n,
  input wire muxed_bus_lines_oe,
  input wire underrun_a,
  input wire send_abort_a,
  input wire send_crc_a,
  input wire tx_enable_a,
  input wire [1:0] modem_ctrl_a
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_underrun;
    underrun_a;
  endsequence
  sequence s_reply;
    (send_abort_a ^ send_crc_a) ##1 (!send_abort_a && !send_crc_a);
  endsequence
  property p_rst;
    $rose(aresetn) |-> modem_ctrl_a == 2'b11 && !tx_enable_a && int_n && !muxed_bus_lines_oe;
  endproperty
  property p_ur;
    s_underrun |=> s_reply;
  endproperty
  property p_cause;
    send_abort_a || send_crc_a |-> $past(underrun_a);
  endproperty
  property p_oe_rise;
    $rose(muxed_bus_lines_oe) |-> int_n && !chain_enable_out;
  endproperty
  property p_oe_ack;
    muxed_bus_lines_oe |-> $past(acknowledge_strobe);
  endproperty
  property p_chain;
    chain_enable_out |-> $past(chain_enable_in);
  endproperty
  property p_bdone;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rdone;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  a_ur: assert property (p_ur) else $error("no single underrun reply");
  a_cause: assert property (p_cause) else $error("reply without underrun");
  a_oe_rise: assert property (p_oe_rise) else $error("vector before service");
  a_oe_ack: assert property (p_oe_ack) else $error("bus driven outside ack");
  a_chain: assert property (p_chain) else $error("chain out without chain in");
  a_bdone: assert property (p_bdone) else $error("write response held");
  a_rdone: assert property (p_rdone) else $error("read response held");
endmodule
bind master_irq_and_line_control mic_asserts i_chk (.*);

/* chain_model.sv */
// daisy chain host: upstream enable, acknowledge strobe
// assumes go is a one-cycle request
`timescale 1ns/1ps
module chain_model (
  input wire aclk,
  input wire go,
  input wire up,
  input wire int_n,
  output wire chain_enable_in,
  output wire acknowledge_strobe
);
  logic [2:0] n = 3'h0;
  assign chain_enable_in = up;
  assign acknowledge_strobe = n != 3'h0;
  // acknowledge only a raised request, strobe held four whole cycles
  always @(posedge aclk)
  begin
    if (go && !int_n) n <= 3'h4;
    else if (n != 3'h0) n <= n - 3'h1;
  end
endmodule

/* tb_top.sv */
// self-checking bench: axi4-lite host, event pulses, chain model
// assumes the checker is bound into the top module
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn = 0, go = 0, up = 1;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [15:0] ev = 0, res = 0;
  logic [1:0] br, rr;
  logic [39:0] r;
  int i, failures = 0, checks_done = 0, cyc = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire chain_enable_in, chain_enable_out, acknowledge_strobe, int_n, muxed_bus_lines_oe;
  wire [7:0] muxed_bus_lines_out;
  wire rx_avail_a = ev[0], rx_special_a = ev[1], end_of_poll_a = ev[2], flag_out_a = ev[3];
  wire byte_done_a = ev[4], underrun_a = ev[5], closing_done_a = ev[6], frame_end_a = ev[7];
  wire rx_avail_b = ev[8], rx_special_b = ev[9], end_of_poll_b = ev[10], flag_out_b = ev[11];
  wire byte_done_b = ev[12], underrun_b = ev[13], closing_done_b = ev[14], frame_end_b = ev[15];
  wire [15:0] crc_residue_a = res, crc_residue_b = res, crc_preset_a, crc_preset_b;
  wire rx_enable_a, tx_enable_a, crc_invert_a, crc_ok_a, loop_gate_a, loop_delay_a;
  wire loop_tx_active_a, mark_idle_a, send_open_flag_a, send_abort_a, send_crc_a;
  wire rx_enable_b, tx_enable_b, crc_invert_b, crc_ok_b, loop_gate_b, loop_delay_b;
  wire loop_tx_active_b, mark_idle_b, send_open_flag_b, send_abort_b, send_crc_b;
  wire [1:0] modem_ctrl_a, encoding_a, modem_ctrl_b, encoding_b;
  // write addr, write data, read addr, read data, {bresp, rresp}
  logic [39:0] rows [9] = '{40'h18_00_08_C0_00, 40'h04_20_04_20_00, 40'h24_40_24_40_00,
    40'h04_60_04_60_00, 40'h24_00_24_00_00, 40'h00_1F_20_1F_00, 40'h20_08_00_08_00,
    40'h30_55_30_00_22, 40'h14_FF_14_00_20};
  master_irq_and_line_control i_dut (.*);
  chain_model i_host (.*);
  initial
  begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      stop_test;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task rd(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  task pulse(input int k);
    @(posedge aclk);
    ev[k] <= 1;
    @(posedge aclk);
    ev[k] <= 0;
    #1;
  endtask
  task ack;
    @(posedge aclk);
    go <= 1;
    @(posedge aclk);
    go <= 0;
    tick(3);
  endtask
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    tick(1);
    chk({modem_ctrl_a, modem_ctrl_b, rx_enable_a, tx_enable_a, encoding_a, encoding_b,
      int_n, muxed_bus_lines_oe}, 12'b1111_0000_0010);
    for (i = 0; i < 9; i++)
    begin
      r = rows[i];
      wr(r[39:32], {24'h0, r[31:24]});
      chk(br, r[7:4]);
      rd(r[23:16]);
      chk(rv, r[15:8]);
      chk(rr, r[3:0]);
      if (r[39:32] == 8'h04) chk(encoding_a, r[30:29]);
      if (r[39:32] == 8'h24) chk(encoding_b, r[30:29]);
    end
    $display("table done");
    for (i = 0; i < 16; i++) if (i != 5) pulse(i);
    wr(8'h08, 32'h23F);
    wr(8'h28, 32'h0CF);
    wr(8'h00, 32'h09);
    pulse(0);
    pulse(8);
    tick(2);
    chk(int_n, 0);
    ack;
    chk({muxed_bus_lines_oe, muxed_bus_lines_out, int_n, chain_enable_out}, 11'h432);
    wr(8'h10, 32'h100);
    wr(8'h00, 32'h39);
    rd(8'h2C);
    chk(rv, 32'h30);
    rd(8'h10);
    chk({rv[15:8], int_n}, 9'h081);
    wr(8'h10, 32'h100);
    wr(8'h00, 32'h0B);
    ack;
    chk({muxed_bus_lines_oe, int_n}, 2'b01);
    wr(8'h10, 32'h100);
    wr(8'h00, 32'h21);
    rd(8'h0C);
    rd(8'h10);
    chk({rv[15:8], chain_enable_out}, 9'h001);
    @(posedge aclk) up <= 0;
    tick(2);
    chk(chain_enable_out, 0);
    @(posedge aclk) up <= 1;
    wr(8'h00, 32'h04);
    tick(2);
    chk(chain_enable_out, 0);
    $display("interrupt tests done");
    wr(8'h00, 32'hDF);
    tick(5);
    rd(8'h00);
    chk(rv, 32'h1C);
    rd(8'h10);
    chk(rv, 32'h0);
    rd(8'h04);
    chk(rv, 32'h0);
    rd(8'h08);
    chk(rv, 32'hC0);
    wr(8'h08, 32'h23F);
    for (i = 0; i < 2; i++)
    begin
      wr(8'h04, i ? 32'h80 : 32'h8C);
      pulse(5);
      chk({send_abort_a, send_crc_a}, i ? 2'b01 : 2'b10);
    end
    chk({crc_preset_a, crc_invert_a}, 17'h1FFFF);
    pulse(6);
    tick(2);
    rd(8'h10);
    chk(rv[5:4], 2'b11);
    wr(8'h04, 32'h08);
    pulse(4);
    chk({mark_idle_a, crc_preset_a}, 17'h10000);
    for (i = 0; i < 2; i++)
    begin
      @(posedge aclk) res <= i ? 16'h1D0E : 16'h1D0F;
      pulse(7);
      tick(1);
      chk(crc_ok_a, i == 0);
    end
    wr(8'h04, 32'h12);
    tick(2);
    chk(loop_gate_a, 1);
    pulse(2);
    tick(1);
    chk(loop_tx_active_a, 1);
    wr(8'h04, 32'h02);
    pulse(3);
    tick(1);
    chk({loop_delay_a, loop_tx_active_a}, 2'b10);
    for (i = 0; i < 2; i++)
    begin
      wr(i ? 8'h28 : 8'h08, 32'h230);
      wr(8'h00, i ? 32'h40 : 32'h80);
      tick(5);
      chk(i ? {rx_enable_b, tx_enable_b, modem_ctrl_b} :
        {rx_enable_a, tx_enable_a, modem_ctrl_a}, 4'b0011);
      rd(i ? 8'h24 : 8'h04);
      chk(rv, 32'h0);
    end
    $display("reset and line tests done");
    stop_test;
  end
endmodule
